/* File: hdl/clock_chip_irq_status_logic.sv */
/*
  Interrupt status and enable logic of a clock multiplier, with an
  AXI4-Lite register slave. Assumes status sources arrive asynchronously,
  while per-output pending flags and the auto-configuration busy level
  come from logic on aclk.
*/
// Summary of operation
// R1: Host writes ignored during auto-configuration.
// R2: Host polls a harmless enable to detect completion.
// R3: Pin enables gate pin change flags.
// R4: Input summary bit 3 is crystal flag and enable.
// R5: Input summary bits 2:0 gate input flags.
// R6: Output summary low shows outputs 8 to 1.
// R7: Output summary high shows outputs 10, 9.
// R8: PLL summary bit 0 ORs enabled PLL flags.
// R9: Frequency-low flag sets on indication, write-1 clears.
// R10: Bit 6 shows frequency low now.
// R11: Frequency-high flag sets on indication, write-1 clears.
// R12: Bit 4 shows frequency high now.
// R13: Lock flag sets on either lock change.
// R14: Bit 2 shows lock state now.
// R15: Bit 0 shows PLL selected reference.
// R16: Second path status shows its reference.
// R17: PLL enables at bits 7, 5, 3.
// R18: Crystal status register mirrors input clock layout.
// R19: Global pending from enabled summaries or pins.
// R20: Pin flags set on any change, write-1 clears.
// R21: Input valid flags set on any change.
// R22: Summaries are live views, not writable.
// R23: Bits reset to zero, live bits track.
`timescale 1ns/10ps
`default_nettype none
`include "clk_irq_defs.svh"

module clock_chip_irq_status_logic
    import clk_irq_pkg::*;
(
    input  wire logic                   aclk,            // System clock, 100 MHz
    input  wire logic                   aresetn,         // Synchronous reset, active low
    input  wire logic [`AXI_ADDR_W-1:0] awaddr,          // Write address
    input  wire logic                   awvalid,         // Write address valid
    output logic                        awready,         // Write address ready
    input  wire logic [31:0]            wdata,           // Write data
    input  wire logic [3:0]             wstrb,           // Write byte strobes
    input  wire logic                   wvalid,          // Write data valid
    output logic                        wready,          // Write data ready
    output logic [1:0]                  bresp,           // Write response
    output logic                        bvalid,          // Write response valid
    input  wire logic                   bready,          // Write response ready
    input  wire logic [`AXI_ADDR_W-1:0] araddr,          // Read address
    input  wire logic                   arvalid,         // Read address valid
    output logic                        arready,         // Read address ready
    output logic [31:0]                 rdata,           // Read data
    output logic [1:0]                  rresp,           // Read response
    output logic                        rvalid,          // Read data valid
    input  wire logic                   rready,          // Read data ready
    input  wire logic                   autoconfig_busy, // Auto-configuration running
    input  wire logic [3:0]             pin_state,       // General-purpose pin levels
    input  wire logic [2:0]             input_valid_now, // Input clocks 3..1 valid
    input  wire logic                   crystal_valid_now, // Crystal input valid
    input  wire logic                   pll_freq_low_now,  // PLL input too slow
    input  wire logic                   pll_freq_high_now, // PLL input too fast
    input  wire logic                   pll_locked_now,    // PLL lock
    input  wire logic                   selected_reference, // PLL alternate in use
    input  wire logic                   second_path_ref,   // Second path alternate in use
    input  wire logic [9:0]             output_pending,    // Outputs 10..1 flag and enable
    output logic                        irq_pending        // Global pending, registered
);

    ////////////////////////////////////////////////////////////////////////////
    // Status sources

    logic [`SRC_COUNT-1:0] src_raw;
    logic [`SRC_COUNT-1:0] src_now;
    logic [`SRC_COUNT-1:0] src_latched;
    logic [`SRC_COUNT-1:0] src_clear;
    logic [1:0]            ref_now;

    // Bits: 3:0 pins, 6:4 inputs 1..3, 7 crystal, 8 low, 9 high, 10 lock
    assign src_raw = {pll_locked_now, pll_freq_high_now, pll_freq_low_now,
                      crystal_valid_now, input_valid_now, pin_state};

    status_sync_latch #(
        .WIDTH     (`SRC_COUNT),
        .RISE_ONLY (`SRC_RISE_ONLY)
    ) u_sources (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     (src_raw),
        .clear   (src_clear),
        .now     (src_now),
        .latched (src_latched)                                   // [R9] [R11] [R13] [R20] [R21]
    );

    status_sync_latch #(
        .WIDTH     (2),
        .RISE_ONLY (2'b00)
    ) u_refs (
        .aclk    (aclk),
        .aresetn (aresetn),
        .raw     ({second_path_ref, selected_reference}),
        .clear   (2'b00),
        .now     (ref_now),
        .latched ()
    );

    logic [3:0] pin_now;
    logic [3:0] pin_flag;
    logic [2:0] in_now;
    logic [2:0] in_flag;
    logic       xa_now;
    logic       xa_flag;
    logic [2:0] pll_now;
    logic [2:0] pll_flag;

    assign pin_now  = src_now[3:0];
    assign pin_flag = src_latched[3:0];
    assign in_now   = src_now[6:4];
    assign in_flag  = src_latched[6:4];
    assign xa_now   = src_now[7];
    assign xa_flag  = src_latched[7];
    // Ordered low, high, lock from bit 2 down
    assign pll_now  = {src_now[8], src_now[9], src_now[10]};
    assign pll_flag = {src_latched[8], src_latched[9], src_latched[10]};

    ////////////////////////////////////////////////////////////////////////////
    // Enables and summaries

    logic [3:0] pin_en;
    logic [2:0] in_en;
    logic       xa_en;
    logic [2:0] pll_en;
    logic       global_en;

    logic [2:0] in_sum;
    logic       xa_sum;
    logic       pll_sum;
    logic       in_any;
    logic       out_any;
    logic       pin_any;
    logic       pending;

    assign in_sum  = in_flag & in_en;                            // [R5] [R22]
    assign xa_sum  = xa_flag & xa_en;                            // [R4]
    assign pll_sum = |(pll_flag & pll_en);                       // [R8] [R17]
    assign in_any  = xa_sum | (|in_sum);
    assign out_any = |output_pending;                            // [R6] [R7]
    assign pin_any = |(pin_flag & pin_en);                       // [R3]
    assign pending = (global_en & (in_any | out_any | pll_sum)) | pin_any; // [R19]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pending <= 1'b0;
        end else begin
            irq_pending <= pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel

    write_state_type w_state;
    logic            w_take;
    logic [7:0]      w_idx;
    logic            w_hit;
    logic            w_do;
    logic [7:0]      w_byte;

    assign w_take = (w_state == W_ACCEPT);
    assign w_idx  = awaddr[`AXI_ADDR_W-1:2];
    assign w_byte = wdata[7:0];
    // Host writes are dropped while auto-configuration owns the registers
    assign w_do   = w_take && wstrb[0] && !autoconfig_busy;      // [R1]

    always_comb begin
        w_hit = 1'b1;
        if (w_idx == `IDX_PIN_STATUS) begin
            w_hit = 1'b1;
        end else if (w_idx == `IDX_INT_STATUS || w_idx == `IDX_GLOBAL) begin
            w_hit = 1'b1;
        end else if (w_idx >= `IDX_IN_SUM && w_idx <= `IDX_PLL_IRQ_EN) begin
            w_hit = 1'b1;
        end else if (w_idx >= `IDX_CRYSTAL && w_idx <= `IDX_INPUT3) begin
            w_hit = 1'b1;
        end else begin
            w_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_state <= W_IDLE;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else begin
            case (w_state)
                W_IDLE: begin
                    if (awvalid && wvalid) begin
                        awready <= 1'b1;
                        wready  <= 1'b1;
                        w_state <= W_ACCEPT;
                    end
                end
                W_ACCEPT: begin
                    awready <= 1'b0;
                    wready  <= 1'b0;
                    bvalid  <= 1'b1;
                    bresp   <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
                    w_state <= W_RESP;
                end
                W_RESP: begin
                    if (bready) begin
                        bvalid  <= 1'b0;
                        w_state <= W_IDLE;
                    end
                end
                default: begin
                    w_state <= W_IDLE;
                end
            endcase
        end
    end

    // Write-1-to-clear pulses for the latched flags
    always_comb begin
        src_clear = '0;
        if (w_do) begin
            if (w_idx == `IDX_PIN_STATUS) begin
                src_clear[3:0] = w_byte[7:4];                    // [R20]
            end else if (w_idx == `IDX_INPUT1) begin
                src_clear[4] = w_byte[`BIT_CLK_LATCHED];         // [R21]
            end else if (w_idx == `IDX_INPUT2) begin
                src_clear[5] = w_byte[`BIT_CLK_LATCHED];
            end else if (w_idx == `IDX_INPUT3) begin
                src_clear[6] = w_byte[`BIT_CLK_LATCHED];
            end else if (w_idx == `IDX_CRYSTAL) begin
                src_clear[7] = w_byte[`BIT_CLK_LATCHED];         // [R18]
            end else if (w_idx == `IDX_PLL_STATUS) begin
                src_clear[8]  = w_byte[`BIT_PLL_LOW];            // [R9]
                src_clear[9]  = w_byte[`BIT_PLL_HIGH];           // [R11]
                src_clear[10] = w_byte[`BIT_PLL_LOCK];           // [R13]
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_en    <= 4'(`ENABLE_RESET);                       // [R23]
            in_en     <= 3'h0;
            xa_en     <= 1'b0;
            pll_en    <= 3'h0;
            global_en <= 1'b0;
        end else if (w_do) begin
            if (w_idx == `IDX_GLOBAL) begin
                pin_en <= w_byte[3:0];                           // [R3]
            end else if (w_idx == `IDX_INT_STATUS) begin
                global_en <= w_byte[`BIT_GLOBAL_EN];
            end else if (w_idx == `IDX_PLL_IRQ_EN) begin
                pll_en <= {w_byte[`BIT_PLL_LOW], w_byte[`BIT_PLL_HIGH],
                           w_byte[`BIT_PLL_LOCK]};               // [R17]
            end else if (w_idx == `IDX_CRYSTAL) begin
                xa_en <= w_byte[`BIT_CLK_IRQ_EN];                // [R18]
            end else if (w_idx == `IDX_INPUT1) begin
                in_en[0] <= w_byte[`BIT_CLK_IRQ_EN];
            end else if (w_idx == `IDX_INPUT2) begin
                in_en[1] <= w_byte[`BIT_CLK_IRQ_EN];
            end else if (w_idx == `IDX_INPUT3) begin
                in_en[2] <= w_byte[`BIT_CLK_IRQ_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    read_state_type r_state;
    logic [7:0]     r_idx;
    logic [7:0]     r_byte;
    logic           r_hit;

    assign r_idx = araddr[`AXI_ADDR_W-1:2];

    always_comb begin
        r_hit  = 1'b1;
        r_byte = 8'h00;
        if (r_idx == `IDX_PIN_STATUS) begin
            r_byte = {pin_flag, pin_now};
        end else if (r_idx == `IDX_INT_STATUS) begin
            r_byte = {2'b00, out_any, in_any, 1'b0, pll_sum, global_en, pending};
        end else if (r_idx == `IDX_GLOBAL) begin
            r_byte = {~autoconfig_busy, 3'b000, pin_en};
        end else if (r_idx == `IDX_IN_SUM) begin
            r_byte = {4'h0, xa_sum, in_sum};                     // [R4] [R5]
        end else if (r_idx == `IDX_OUT_SUM_LOW) begin
            r_byte = output_pending[7:0];                        // [R6]
        end else if (r_idx == `IDX_OUT_SUM_HIGH) begin
            r_byte = {6'h00, output_pending[9:8]};               // [R7]
        end else if (r_idx == `IDX_PLL_SUM) begin
            r_byte = {7'h00, pll_sum};                           // [R8]
        end else if (r_idx == `IDX_PLL_STATUS) begin
            // Live bits: low 6, high 4, lock 2, reference 0
            r_byte = {pll_flag[2], pll_now[2], pll_flag[1], pll_now[1],
                      pll_flag[0], pll_now[0], 1'b0, ref_now[0]}; // [R10] [R12] [R14] [R15]
        end else if (r_idx == `IDX_PATH2_STATUS) begin
            r_byte = {7'h00, ref_now[1]};                        // [R16]
        end else if (r_idx == `IDX_PLL_IRQ_EN) begin
            r_byte = {pll_en[2], 1'b0, pll_en[1], 1'b0, pll_en[0], 3'b000};
        end else if (r_idx == `IDX_CRYSTAL) begin
            r_byte = {4'h0, xa_en, xa_flag, xa_now, 1'b0};       // [R18]
        end else if (r_idx == `IDX_INPUT1) begin
            r_byte = {4'h0, in_en[0], in_flag[0], in_now[0], 1'b0};
        end else if (r_idx == `IDX_INPUT2) begin
            r_byte = {4'h0, in_en[1], in_flag[1], in_now[1], 1'b0};
        end else if (r_idx == `IDX_INPUT3) begin
            r_byte = {4'h0, in_en[2], in_flag[2], in_now[2], 1'b0};
        end else begin
            r_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_state <= R_IDLE;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else begin
            case (r_state)
                R_IDLE: begin
                    if (arvalid) begin
                        arready <= 1'b1;
                        r_state <= R_ACCEPT;
                    end
                end
                R_ACCEPT: begin
                    arready <= 1'b0;
                    rvalid  <= 1'b1;
                    rdata   <= {24'h00_0000, r_byte};
                    rresp   <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
                    r_state <= R_DATA;
                end
                R_DATA: begin
                    if (rready) begin
                        rvalid  <= 1'b0;
                        r_state <= R_IDLE;
                    end
                end
                default: begin
                    r_state <= R_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_read_of(logic [7:0] idx);
        r_state == R_ACCEPT && r_idx == idx;
    endsequence

    sequence s_busy_write;
        w_take && autoconfig_busy;
    endsequence

    property p_busy_write;
        s_busy_write |=> $stable(pin_en) && $stable(pll_en) && $stable(global_en);
    endproperty
    a_busy_write: assert property (p_busy_write) else $error("write during autoconfig"); // [R1]

    property p_pin_irq;
        (|(pin_flag & pin_en)) |=> irq_pending;
    endproperty
    a_pin_irq: assert property (p_pin_irq) else $error("pin event not pending"); // [R3]

    property p_global_gate;
        (!global_en && !pin_any) |=> !irq_pending;
    endproperty
    a_global_gate: assert property (p_global_gate) else $error("pending while gated"); // [R19]

    property p_high_zero;
        s_read_of(`IDX_OUT_SUM_HIGH) |=> rvalid && rdata[7:2] == 6'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("upper bits set"); // [R7]

    property p_in_sum_read;
        s_read_of(`IDX_IN_SUM) |=> rdata[3] == $past(xa_flag & xa_en);
    endproperty
    a_in_sum_read: assert property (p_in_sum_read) else $error("crystal summary wrong"); // [R4]

    property p_low_latch;
        $rose(pll_now[2]) |=> pll_flag[2];
    endproperty
    a_low_latch: assert property (p_low_latch) else $error("low flag missed"); // [R9]

    property p_lock_latch;
        $changed(pll_now[0]) |=> pll_flag[0];
    endproperty
    a_lock_latch: assert property (p_lock_latch) else $error("lock change missed"); // [R13]

    property p_pll_sum_read;
        s_read_of(`IDX_PLL_SUM) |=> rdata[0] == $past(|(pll_flag & pll_en));
    endproperty
    a_pll_sum_read: assert property (p_pll_sum_read) else $error("pll summary wrong"); // [R8]

    property p_read_answer;
        (r_state == R_IDLE && arvalid) |=> arready ##1 rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late"); // [R22]

endmodule

`default_nettype wire

/* File: hdl/clk_irq_defs.svh */
/*
  Register indices, field positions, reset values and bus codes
  for the clock-chip interrupt status block.
  Assumes byte address = 4 * register index on the AXI4-Lite bus.
*/
`ifndef CLK_IRQ_DEFS_SVH
`define CLK_IRQ_DEFS_SVH

`define AXI_ADDR_W        10
`define IDX_PIN_STATUS    8'h41
`define IDX_INT_STATUS    8'h42
`define IDX_GLOBAL        8'h43
`define IDX_IN_SUM        8'h44
`define IDX_OUT_SUM_LOW   8'h45
`define IDX_OUT_SUM_HIGH  8'h46
`define IDX_PLL_SUM       8'h47
`define IDX_PLL_STATUS    8'h48
`define IDX_PATH2_STATUS  8'h49
`define IDX_PLL_IRQ_EN    8'h4A
`define IDX_CRYSTAL       8'h4C
`define IDX_INPUT1        8'h4D
`define IDX_INPUT2        8'h4E
`define IDX_INPUT3        8'h4F

`define BIT_PLL_LOW       7
`define BIT_PLL_HIGH      5
`define BIT_PLL_LOCK      3
`define BIT_CLK_IRQ_EN    3
`define BIT_CLK_LATCHED   2
`define BIT_GLOBAL_EN     1

`define SRC_COUNT         11
`define SRC_RISE_ONLY     11'h300
`define ENABLE_RESET      8'h00
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

/* File: hdl/clk_irq_pkg.sv */
/*
  Types for the clock-chip interrupt status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package clk_irq_pkg;

    typedef enum logic [2:0] {
        W_IDLE   = 3'b001,
        W_ACCEPT = 3'b010,
        W_RESP   = 3'b100
    } write_state_type;

    typedef enum logic [2:0] {
        R_IDLE   = 3'b001,
        R_ACCEPT = 3'b010,
        R_DATA   = 3'b100
    } read_state_type;

endpackage

/* File: hdl/status_sync_latch.sv */
/*
  Per-bit two-flop synchroniser, change detector and write-1-to-clear
  latched flag. Assumes raw inputs are asynchronous to aclk and that
  clear is a one-cycle pulse from logic on aclk.
*/
`timescale 1ns/10ps
`default_nettype none

module status_sync_latch #(
    parameter int                 WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RISE_ONLY = '0
) (
    input  wire logic             aclk,     // System clock
    input  wire logic             aresetn,  // Synchronous reset, active low
    input  wire logic [WIDTH-1:0] raw,      // Asynchronous sources
    input  wire logic [WIDTH-1:0] clear,    // Clear pulses
    output logic      [WIDTH-1:0] now,      // Synchronised level
    output logic      [WIDTH-1:0] latched   // Sticky change flags
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] event_seen;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage1[i] <= 1'b0;
                now[i]    <= 1'b0;
                prev[i]   <= 1'b0;
            end else begin
                stage1[i] <= raw[i];
                now[i]    <= stage1[i];
                prev[i]   <= now[i];
            end
        end

        assign event_seen[i] = RISE_ONLY[i] ? (now[i] & ~prev[i]) : (now[i] ^ prev[i]);

        // A change in the clearing cycle keeps the flag set
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                latched[i] <= 1'b0;
            end else if (event_seen[i]) begin
                latched[i] <= 1'b1;
            end else if (clear[i]) begin
                latched[i] <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_set_wins;
        |event_seen |=> |latched;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("change lost"); // [R21]

    property p_clear_works;
        (clear[0] && !event_seen[0]) |=> !latched[0];
    endproperty
    a_clear_works: assert property (p_clear_works) else $error("flag not cleared"); // [R20]

endmodule

`default_nettype wire

/* File: verification/host_bus_master.sv */
/*
  Host model: AXI4-Lite master with one write and one read task.
  Assumes a single aclk shared with the register slave.
*/
`timescale 1ns/10ps
`default_nettype none

module host_bus_master (
    input  wire logic        aclk,    // Clock
    output logic [9:0]       awaddr,  // AW addr
    output logic             awvalid, // AW valid
    input  wire logic        awready, // AW ready
    output logic [31:0]      wdata,   // W data
    output logic [3:0]       wstrb,   // W strobes
    output logic             wvalid,  // W valid
    input  wire logic        wready,  // W ready
    input  wire logic [1:0]  bresp,   // B resp
    input  wire logic        bvalid,  // B valid
    output logic             bready,  // B ready
    output logic [9:0]       araddr,  // AR addr
    output logic             arvalid, // AR valid
    input  wire logic        arready, // AR ready
    input  wire logic [31:0] rdata,   // R data
    input  wire logic [1:0]  rresp,   // R resp
    input  wire logic        rvalid,  // R valid
    output logic             rready   // R ready
);

    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = 49'h0;
        {araddr, arvalid, rready} = 12'h000;
    end

    // Address and data go out together and drop once taken
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= {i, 2'b00};
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge aclk); while (!(awready && wready));
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        awaddr  <= ~awaddr;
        wdata   <= ~wdata;
        do @(posedge aclk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        araddr  <= ~araddr;
        do @(posedge aclk); while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask

endmodule

`default_nettype wire

/* File: verification/tb_clock_chip_irq_status_logic.sv */
/*
  Self-checking bench for the interrupt status block.
  Assumes the host model drives the register bus.
*/
`timescale 1ns/10ps
`default_nettype none
`include "clk_irq_defs.svh"

module tb_clock_chip_irq_status_logic;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  awaddr, araddr, output_pending;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, pin_state;
    logic [2:0]  input_valid_now;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic        rvalid, rready, autoconfig_busy, crystal_valid_now, pll_freq_low_now;
    logic        pll_freq_high_now, pll_locked_now, selected_reference, second_path_ref;
    logic        irq_pending;
    logic [7:0]  got;
    int          n_errors = 0;
    int          samples_checked = 0;

    typedef struct packed {
        logic [9:0] pend;
        logic [1:0] refs;
        logic [7:0] idx;
        logic [7:0] exp;
    } row_type;

    row_type    rows [6] = '{'{10'h001, 2'h0, 8'h45, 8'h01}, '{10'h280, 2'h0, 8'h45, 8'h80},
                             '{10'h280, 2'h0, 8'h46, 8'h02}, '{10'h100, 2'h1, 8'h46, 8'h01},
                             '{10'h000, 2'h1, 8'h48, 8'h01}, '{10'h000, 2'h2, 8'h49, 8'h01}};
    logic [7:0] zero_idx [10] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49,
                                 8'h4A, 8'h4C};

    always #5 aclk = ~aclk;

    clock_chip_irq_status_logic dut (.*);
    host_bus_master             host (.*);

    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk(input logic [7:0] i, input logic [7:0] e);
        host.rd(i, got, resp);
        cmp(got, e);
        cmp({6'h00, resp}, {6'h00, `RESP_OKAY});
    endtask

    task automatic put(input logic [7:0] i, input logic [7:0] d);
        host.wr(i, d, 4'hF, resp);
    endtask

    task automatic settle;
        repeat (4) @(posedge aclk);
    endtask

    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_errors++;
        test_done();
    end

    initial begin
        {autoconfig_busy, pin_state, input_valid_now, crystal_valid_now, pll_freq_low_now,
         pll_freq_high_now, pll_locked_now, selected_reference, second_path_ref,
         output_pending} = 24'h800000;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (zero_idx[k]) chk(zero_idx[k], 8'h00);
        put(`IDX_GLOBAL, 8'h08);
        chk(`IDX_GLOBAL, 8'h00);
        @(posedge aclk);
        autoconfig_busy <= 1'b0;
        put(`IDX_GLOBAL, 8'h08);
        chk(`IDX_GLOBAL, 8'h88);
        foreach (rows[k]) begin
            @(posedge aclk);
            output_pending <= rows[k].pend;
            {second_path_ref, selected_reference} <= rows[k].refs;
            settle();
            chk(rows[k].idx, rows[k].exp);
        end
        @(posedge aclk);
        pin_state <= 4'h8;
        settle();
        chk(`IDX_PIN_STATUS, 8'h88);
        chk(`IDX_INT_STATUS, 8'h01);
        cmp({7'h00, irq_pending}, 8'h01);
        @(posedge aclk);
        pin_state <= 4'h1;
        settle();
        chk(`IDX_PIN_STATUS, 8'h91);
        put(`IDX_PIN_STATUS, 8'h80);
        chk(`IDX_PIN_STATUS, 8'h11);
        chk(`IDX_INT_STATUS, 8'h00);
        host.wr(`IDX_GLOBAL, 8'h00, 4'h0, resp);
        chk(`IDX_GLOBAL, 8'h88);
        put(`IDX_PLL_IRQ_EN, 8'hA8);
        chk(`IDX_PLL_IRQ_EN, 8'hA8);
        @(posedge aclk);
        pll_freq_low_now <= 1'b1;
        settle();
        chk(`IDX_PLL_STATUS, 8'hC0);
        chk(`IDX_PLL_SUM, 8'h01);
        put(`IDX_INT_STATUS, 8'h02);
        chk(`IDX_INT_STATUS, 8'h07);
        @(posedge aclk);
        pll_freq_low_now <= 1'b0;
        settle();
        chk(`IDX_PLL_STATUS, 8'h80);
        put(`IDX_PLL_STATUS, 8'h80);
        chk(`IDX_PLL_SUM, 8'h00);
        @(posedge aclk);
        pll_freq_high_now <= 1'b1;
        pll_locked_now <= 1'b1;
        settle();
        chk(`IDX_PLL_STATUS, 8'h3C);
        put(`IDX_PLL_STATUS, 8'h28);
        @(posedge aclk);
        pll_locked_now <= 1'b0;
        settle();
        chk(`IDX_PLL_STATUS, 8'h18);
        put(`IDX_PLL_IRQ_EN, 8'h20);
        chk(`IDX_PLL_SUM, 8'h00);
        put(`IDX_PLL_IRQ_EN, 8'h08);
        put(`IDX_PLL_SUM, 8'h00);
        chk(`IDX_PLL_SUM, 8'h01);
        put(`IDX_PLL_IRQ_EN, 8'h00);
        @(posedge aclk);
        crystal_valid_now <= 1'b1;
        input_valid_now <= 3'h4;
        settle();
        chk(`IDX_CRYSTAL, 8'h06);
        chk(`IDX_IN_SUM, 8'h00);
        put(`IDX_CRYSTAL, 8'h08);
        put(`IDX_INPUT3, 8'h08);
        chk(`IDX_IN_SUM, 8'h0C);
        chk(`IDX_INT_STATUS, 8'h13);
        put(`IDX_INPUT3, 8'h0C);
        chk(`IDX_INPUT3, 8'h0A);
        chk(`IDX_IN_SUM, 8'h08);
        host.rd(8'h60, got, resp);
        cmp({6'h00, resp}, {6'h00, `RESP_SLVERR});
        host.wr(8'h60, 8'h01, 4'hF, resp);
        cmp({6'h00, resp}, {6'h00, `RESP_SLVERR});
        test_done();
    end

endmodule

`default_nettype wire
